// ### inc/flog_defs.vh
// register offsets, field positions, policy codes and timing counts of the fault log
`ifndef FLOG_DEFS_VH
`define FLOG_DEFS_VH
`define FLOG_CLK_HZ        20000000
`define FLOG_PEAK_SEC      30
`define FLOG_PEAK_CYC      (`FLOG_PEAK_SEC * `FLOG_CLK_HZ)
`define FLOG_MS_CYC        (`FLOG_CLK_HZ / 1000)
`define FLOG_MS_PER_DAY    32'h0526_5C00
`define FLOG_DEPTH         18
`define FLOG_HALF          9
`define FLOG_RAILS         4
`define FLOG_BO_MV         12'hB54
`define FLOG_POL_NOFIFO    2'h0
`define FLOG_POL_FULL      2'h1
`define FLOG_POL_HALF      2'h2
`define FLOG_A_CTRL        8'h00
`define FLOG_A_STAT        8'h04
`define FLOG_A_RTC_MS      8'h08
`define FLOG_A_RTC_DAY     8'h0C
`define FLOG_A_RST_CNT     8'h10
`define FLOG_A_SEL         8'h14
`define FLOG_A_ENT_INFO    8'h18
`define FLOG_A_ENT_MS      8'h1C
`define FLOG_A_ENT_DAY     8'h20
`define FLOG_A_PEAK        8'h24
`define FLOG_C_POL_LSB     0
`define FLOG_C_BO_EN       2
`define FLOG_C_CLR_LOG     8
`define FLOG_C_CLR_RST     9
`define FLOG_C_STORE_ALL   10
`define FLOG_C_RTC_WR      11
`endif

// ### hdl/flog_nvm_port.v
// flash write request sequencer: one write pulse per request taken while idle
`timescale 1ns/10ps
module flog_nvm_port
(
  input  wire       clk,
  input  wire       rst_n,
  input  wire       ce,
  input  wire       req,
  input  wire [2:0] kind,
  input  wire       nvm_ready,
  output reg        nvm_we,
  output reg  [2:0] nvm_kind,
  output reg        busy
);
  ////////////////////////////////////////////////////////////////////////////
  // latch one request, fire it when flash is ready, ignore new ones while busy
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      nvm_we   <= 1'b0;
      nvm_kind <= 3'h0;
      busy     <= 1'b0;
    end
    else if (ce)
    begin
      nvm_we <= 1'b0;
      if (!busy && req)
      begin
        busy     <= 1'b1;
        nvm_kind <= kind;
      end
      else if (busy && nvm_ready)
      begin
        nvm_we <= 1'b1;
        busy   <= 1'b0;
      end
    end
  end
endmodule

// ### hdl/flog_core.v
// fault log engine with brownout-deferred store, run-time clock and ahb-lite registers
//
// Added by the designer: the AHB-Lite slave port and the register offsets.
`timescale 1ns/10ps
`include "flog_defs.vh"
// Contract
// - keep eighteen fault entries plus a persistent reset counter.
// - keep one peak voltage per monitored rail.
// - new peak starts 30 s timer; store interval maximum at its end.
// - entry holds rail, fault type, timestamp and last rail voltage.
// - host reads entries over the register bus.
// - reset counter counts device resets; host can clear it.
// - no-fifo policy keeps first 18 faults, drops the rest.
// - full fifo policy keeps the newest 18, overwriting oldest.
// - half fifo keeps first 9 fixed, newest 9 circular.
// - brownout mode writes clock, peaks, faults only at power-down; store-all still requests a clock write in brownout mode.
// - clock survives resets in brownout mode, else restarts at zero.
// - host may overwrite the run-time clock.
// - brownout declared when supply falls below 2.9 V.
// - brownout mode accumulates log data in ram only.
// - on brownout the whole ram image is copied to flash.
// - brownout mode suppresses flash writes in normal operation; the store-all request (kind 3) is still sent in brownout mode.
// - brownout mode off unless host enables it.
// - run-time clock is two 32-bit counts, milliseconds and days.
// - store-all command saves the run-time clock.
// - each fault is stamped with the current run-time clock.
module flog_core
#(
  parameter PEAK_CYC = `FLOG_PEAK_CYC
)
(
  input  wire        clk,
  input  wire        rst_n,
  input  wire        ce,
  input  wire        hsel,
  input  wire [7:0]  haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output reg  [31:0] hrdata,
  output reg         hreadyout,
  output reg         hresp,
  input  wire        fault_stb,
  input  wire [1:0]  fault_rail,
  input  wire [3:0]  fault_type,
  input  wire        meas_stb,
  input  wire [1:0]  meas_rail,
  input  wire [11:0] meas_mv,
  input  wire [11:0] vcc_mv,
  input  wire        nv_restore,
  input  wire [31:0] nv_rtc_ms,
  input  wire [31:0] nv_rtc_day,
  input  wire [15:0] nv_rst_cnt,
  input  wire        nvm_ready,
  output reg         nvm_we,
  output reg  [2:0]  nvm_kind,
  output reg         brownout
);
  localparam K_PEAK  = 3'h1;
  localparam K_FAULT = 3'h2;
  localparam K_RTC   = 3'h3;
  localparam K_RST   = 3'h4;
  localparam K_IMAGE = 3'h5;
  localparam MS_CYC  = `FLOG_MS_CYC;
  localparam [4:0] HALF_IX = `FLOG_HALF;                  // first slot of the circular half

  ////////////////////////////////////////////////////////////////////////////
  // storage
  reg  [1:0]  ent_rail [0:`FLOG_DEPTH-1];
  reg  [3:0]  ent_type [0:`FLOG_DEPTH-1];
  reg  [31:0] ent_ms   [0:`FLOG_DEPTH-1];
  reg  [31:0] ent_day  [0:`FLOG_DEPTH-1];
  reg  [11:0] ent_mv   [0:`FLOG_DEPTH-1];
  reg  [11:0] last_mv  [0:`FLOG_RAILS-1];
  reg  [11:0] peak_q   [0:`FLOG_RAILS-1];
  reg  [11:0] pk_run_q [0:`FLOG_RAILS-1];
  reg  [31:0] pk_tmr_q [0:`FLOG_RAILS-1];
  reg  [`FLOG_RAILS-1:0] pk_done;
  reg  [1:0]  pol_q;
  reg         bo_en_q;
  reg  [4:0]  cnt_q;
  reg  [4:0]  wr_q;
  reg  [4:0]  sel_q;
  reg  [31:0] rtc_ms_q;
  reg  [31:0] rtc_day_q;
  reg  [14:0] ms_div_q;
  reg  [15:0] rst_cnt_q;
  reg         boot_q;
  reg         bo_done_q;
  reg         a_ph_q;
  reg         a_wr_q;
  reg  [7:0]  a_addr_q;
  reg         req;
  reg  [2:0]  req_kind;
  wire        port_we;
  wire [2:0]  port_kind;
  wire        port_busy;
  wire        a_take;
  wire        wr_hit;
  wire        log_ok;
  wire [4:0]  slot;
  wire [4:0]  wr_next;
  wire        clr_now = wr_hit & (a_addr_q == `FLOG_A_CTRL) & hwdata[`FLOG_C_CLR_LOG];

  ////////////////////////////////////////////////////////////////////////////
  // ahb-lite slave: zero wait states, always okay
  assign a_take = hsel & hready & htrans[1];
  assign wr_hit = a_ph_q & a_wr_q;
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      a_ph_q    <= 1'b0;
      a_wr_q    <= 1'b0;
      a_addr_q  <= 8'h00;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
    else if (ce)
    begin
      a_ph_q   <= a_take;
      a_wr_q   <= hwrite;
      a_addr_q <= haddr;
    end
  end

  // read mux registered at the address phase so hrdata is a flop
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      hrdata <= 32'h0000_0000;
    else if (ce && a_take && !hwrite)
    begin
      case (haddr)
        `FLOG_A_CTRL:     hrdata <= {29'h0, bo_en_q, pol_q};
        `FLOG_A_STAT:     hrdata <= {22'h0, port_busy, brownout, 3'h0, cnt_q};
        `FLOG_A_RTC_MS:   hrdata <= rtc_ms_q;
        `FLOG_A_RTC_DAY:  hrdata <= rtc_day_q;
        `FLOG_A_RST_CNT:  hrdata <= {16'h0, rst_cnt_q};
        `FLOG_A_SEL:      hrdata <= {27'h0, sel_q};
        `FLOG_A_ENT_INFO: hrdata <= (sel_q < cnt_q) ?
          {14'h0, ent_rail[sel_q], ent_type[sel_q], ent_mv[sel_q]} : 32'h0000_0000;
        `FLOG_A_ENT_MS:   hrdata <= (sel_q < cnt_q) ? ent_ms[sel_q] : 32'h0000_0000;
        `FLOG_A_ENT_DAY:  hrdata <= (sel_q < cnt_q) ? ent_day[sel_q] : 32'h0000_0000;
        `FLOG_A_PEAK:     hrdata <= {20'h0, peak_q[sel_q[1:0]]};
        default:          hrdata <= 32'h0000_0000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // policy and slot selection
  assign log_ok = clr_now || (pol_q != `FLOG_POL_NOFIFO) || (cnt_q < `FLOG_DEPTH);
  assign slot   = clr_now ? 5'h00 : (cnt_q < `FLOG_DEPTH) ? cnt_q : wr_q;
  assign wr_next = (pol_q == `FLOG_POL_HALF) ?
    ((wr_q == `FLOG_DEPTH - 1) ? HALF_IX : wr_q + 5'h01) :
    ((wr_q == `FLOG_DEPTH - 1) ? 5'h00 : wr_q + 5'h01);

  // control, run-time clock, reset counter and log writes
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pol_q     <= `FLOG_POL_NOFIFO;
      bo_en_q   <= 1'b0;
      cnt_q     <= 5'h00;
      wr_q      <= 5'h00;
      sel_q     <= 5'h00;
      rtc_ms_q  <= 32'h0000_0000;
      rtc_day_q <= 32'h0000_0000;
      ms_div_q  <= 15'h0000;
      rst_cnt_q <= 16'h0000;
      boot_q    <= 1'b1;
      brownout  <= 1'b0;
      bo_done_q <= 1'b0;
      req       <= 1'b0;
      req_kind  <= 3'h0;
    end
    else if (ce)
    begin
      req <= 1'b0;
      // restore from flash after release and count this reset
      if (boot_q)
      begin
        boot_q    <= 1'b0;
        rst_cnt_q <= nv_rst_cnt + 16'h0001;
        if (nv_restore)
        begin
          rtc_ms_q  <= nv_rtc_ms;
          rtc_day_q <= nv_rtc_day;
        end
        req      <= 1'b1;
        req_kind <= K_RST;
      end
      // ms tick and day rollover
      if (ms_div_q == MS_CYC - 1)
      begin
        ms_div_q <= 15'h0000;
        if (rtc_ms_q == `FLOG_MS_PER_DAY - 1)
        begin
          rtc_ms_q  <= 32'h0000_0000;
          rtc_day_q <= rtc_day_q + 32'h0000_0001;
        end
        else
          rtc_ms_q <= rtc_ms_q + 32'h0000_0001;
      end
      else
        ms_div_q <= ms_div_q + 15'h0001;
      // supply collapse: one full image copy
      if (vcc_mv < `FLOG_BO_MV)
        brownout <= 1'b1;
      if (bo_en_q && brownout && !bo_done_q)
      begin
        bo_done_q <= 1'b1;
        req       <= 1'b1;
        req_kind  <= K_IMAGE;
      end
      // fault capture with timestamp
      if (fault_stb && log_ok)
      begin
        ent_rail[slot] <= fault_rail;
        ent_type[slot] <= fault_type;
        ent_ms[slot]   <= rtc_ms_q;
        ent_day[slot]  <= rtc_day_q;
        ent_mv[slot]   <= last_mv[fault_rail];
        if (cnt_q < `FLOG_DEPTH)
        begin
          cnt_q <= cnt_q + 5'h01;
          wr_q  <= (cnt_q == `FLOG_DEPTH - 1) ?
                   ((pol_q == `FLOG_POL_HALF) ? HALF_IX : 5'h00) : 5'h00;
        end
        else
          wr_q <= wr_next;
        if (!bo_en_q)
        begin
          req      <= 1'b1;
          req_kind <= K_FAULT;
        end
      end
      else if (!bo_en_q && |pk_done)
      begin
        req      <= 1'b1;
        req_kind <= K_PEAK;
      end
      // register writes
      if (wr_hit)
      begin
        case (a_addr_q)
          `FLOG_A_CTRL:
          begin
            pol_q   <= hwdata[`FLOG_C_POL_LSB+1:`FLOG_C_POL_LSB];
            bo_en_q <= hwdata[`FLOG_C_BO_EN];
            if (hwdata[`FLOG_C_CLR_LOG])
            begin
              cnt_q <= {4'h0, fault_stb};
              wr_q  <= 5'h00;                            // a fault in the clear cycle is kept in slot 0
            end
            if (hwdata[`FLOG_C_CLR_RST])
              rst_cnt_q <= 16'h0000;
            if (hwdata[`FLOG_C_CLR_RST] && !bo_en_q)
            begin
              req       <= 1'b1;
              req_kind  <= K_RST;
            end
            if (hwdata[`FLOG_C_STORE_ALL])
            begin
              req      <= 1'b1;
              req_kind <= K_RTC;
            end
          end
          `FLOG_A_RTC_MS:  rtc_ms_q  <= hwdata;
          `FLOG_A_RTC_DAY: rtc_day_q <= hwdata;
          `FLOG_A_SEL:     sel_q     <= hwdata[4:0];
          default:         sel_q     <= sel_q;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // per-rail last value, peak and independent 30 s interval timer
  genvar r;
  generate
    for (r = 0; r < `FLOG_RAILS; r = r + 1)
    begin : g_rail
      always @(posedge clk or negedge rst_n)
      begin
        if (!rst_n)
        begin
          last_mv[r]  <= 12'h000;
          peak_q[r]   <= 12'h000;
          pk_run_q[r] <= 12'h000;
          pk_tmr_q[r] <= 32'h0000_0000;
          pk_done[r]  <= 1'b0;
        end
        else if (ce)
        begin
          pk_done[r] <= 1'b0;
          if (meas_stb && meas_rail == r)
          begin
            last_mv[r] <= meas_mv;
            if (meas_mv > peak_q[r] && meas_mv > pk_run_q[r])
              pk_run_q[r] <= meas_mv;
            if (meas_mv > peak_q[r] && pk_tmr_q[r] == 32'h0000_0000)
              pk_tmr_q[r] <= PEAK_CYC;
          end
          if (pk_tmr_q[r] == 32'h0000_0001)
          begin
            peak_q[r]   <= pk_run_q[r];
            pk_done[r]  <= 1'b1;
            pk_tmr_q[r] <= 32'h0000_0000;
          end
          else if (pk_tmr_q[r] != 32'h0000_0000)
            pk_tmr_q[r] <= pk_tmr_q[r] - 32'h0000_0001;
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // flash request sequencer
  flog_nvm_port u_port
  (
    .clk       (clk),
    .rst_n     (rst_n),
    .ce        (ce),
    .req       (req),
    .kind      (req_kind),
    .nvm_ready (nvm_ready),
    .nvm_we    (port_we),
    .nvm_kind  (port_kind),
    .busy      (port_busy)
  );

  // retime to keep top outputs on flops
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      nvm_we   <= 1'b0;
      nvm_kind <= 3'h0;
    end
    else if (ce)
    begin
      nvm_we   <= port_we;
      nvm_kind <= port_kind;
    end
  end
endmodule

// ### testbench/flog_core_chk.sv
// checker: bus answer and brownout properties of the fault log core
`timescale 1ns/10ps
module flog_core_chk
(
  input wire        clk,
  input wire        rst_n,
  input wire        ce,
  input wire        hsel,
  input wire        hready,
  input wire        hwrite,
  input wire [1:0]  htrans,
  input wire [7:0]  haddr,
  input wire [31:0] hrdata,
  input wire        hreadyout,
  input wire        hresp,
  input wire [11:0] vcc_mv,
  input wire        brownout,
  input wire        nvm_we,
  input wire [2:0]  nvm_kind
);
  wire rd_go;

  default clocking @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  // a read is taken only when the slave is selected and the bus is ready
  assign rd_go = hsel & hready & htrans[1] & ~hwrite & ce;

  ////////////////////////////////////////
  a_ready_high: assert property (hreadyout)
    else $error("slave inserted a wait state");
  a_resp_okay: assert property (!hresp)
    else $error("slave answered with error");
  a_unmap_zero: assert property (rd_go && haddr > 8'h24 |=> hrdata == 32'h0)
    else $error("unmapped read not zero");
  a_rd_hold: assert property (!rd_go |=> $stable(hrdata))
    else $error("read data moved without a read");
  a_bo_detect: assert property (ce && vcc_mv < 12'hB54 |-> ##[1:3] brownout)
    else $error("low supply not flagged");
  a_bo_sticky: assert property (brownout |=> brownout)
    else $error("brownout flag dropped");
  a_we_pulse: assert property (nvm_we |=> !nvm_we)
    else $error("flash write longer than one cycle");
  a_kind_legal: assert property (nvm_we |-> nvm_kind inside {[3'h1:3'h5]})
    else $error("flash write of unknown kind");

  c_bo_rise: cover property ($rose(brownout));
  c_whole: cover property (nvm_we && nvm_kind == 3'h5);
  c_entry: cover property (rd_go && haddr == 8'h18);
endmodule

bind flog_core flog_core_chk u_chk (.clk, .rst_n, .ce, .hsel, .hready, .hwrite, .htrans, .haddr,
  .hrdata, .hreadyout, .hresp, .vcc_mv, .brownout, .nvm_we, .nvm_kind);

// ### testbench/flog_nvm_model.sv
// flash model: accepts flash writes of every kind and tallies them per kind
`timescale 1ns/10ps
module flog_nvm_model
(
  input  wire       clk,
  input  wire       slow,
  input  wire       nvm_we,
  input  wire [2:0] nvm_kind,
  output reg        nvm_ready
);
  integer cnt [0:7];
  integer total;
  integer hold;
  integer i;

  initial
  begin
    for (i = 0; i < 8; i = i + 1)
      cnt[i] = 0;
    total = 0;
    hold = 0;
    nvm_ready = 1'b1;
  end

  // a slow part stays busy a few cycles after each write
  always @(posedge clk)
  begin
    if (nvm_we)
    begin
      cnt[nvm_kind] = cnt[nvm_kind] + 1;
      total = total + 1;
      hold = slow ? 4 : 0;
    end
    else if (hold > 0)
      hold = hold - 1;
    nvm_ready <= (hold == 0);
  end
endmodule

// ### testbench/fault_log_brownout_store_tb_top.sv
// testbench: register-level tests of the fault log core
`timescale 1ns/10ps
`include "flog_defs.vh"
module fault_log_brownout_store_tb_top;
  reg         clk, rst_n, ce, hsel, hwrite, fault_stb, meas_stb, nv_restore, slow;
  reg  [1:0]  htrans, fault_rail, meas_rail;
  reg  [2:0]  hsize;
  reg  [3:0]  fault_type;
  reg  [7:0]  haddr;
  reg  [11:0] meas_mv, vcc_mv;
  reg  [15:0] nv_rst_cnt;
  reg  [31:0] hwdata, nv_rtc_ms, nv_rtc_day, rv;
  wire [31:0] hrdata;
  wire        hreadyout, hresp, nvm_ready, nvm_we, brownout;
  wire [2:0]  nvm_kind;
  integer     err_count, check_count, p, i, s, f, n;

  // short peak interval keeps the run small
  flog_core #(.PEAK_CYC(20)) dut
  (
    .clk, .rst_n, .ce, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout),
    .hrdata, .hreadyout, .hresp, .fault_stb, .fault_rail, .fault_type, .meas_stb, .meas_rail,
    .meas_mv, .vcc_mv, .nv_restore, .nv_rtc_ms, .nv_rtc_day, .nv_rst_cnt, .nvm_ready, .nvm_we,
    .nvm_kind, .brownout
  );
  flog_nvm_model nvm (.clk, .slow, .nvm_we, .nvm_kind, .nvm_ready);

  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  ////////////////////////////////////////
  task complete_run;
  begin
    if (err_count == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  end
  endtask

  task chk(input [31:0] got, input [31:0] exp);
  begin
    check_count = check_count + 1;
    if (got !== exp)
    begin
      err_count = err_count + 1;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  end
  endtask

  // one single transfer, waiting on ready in both phases
  task bus(input w, input [7:0] a, input [31:0] d);
  begin
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    @(posedge clk);
    while (hreadyout !== 1'b1)
      @(posedge clk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge clk);
    while (hreadyout !== 1'b1)
      @(posedge clk);
    rv = hrdata;
  end
  endtask

  task rd(input [7:0] a, input [31:0] exp);
  begin
    bus(1'b0, a, 32'h0);
    chk(rv, exp);
  end
  endtask

  task wt(input integer k);
    repeat (k) @(posedge clk);
  endtask

  // fault k: rail k mod 4, type k mod 16
  task flt(input integer k);
  begin
    @(posedge clk);
    fault_stb <= 1'b1;
    fault_rail <= k[1:0];
    fault_type <= k[3:0];
    @(posedge clk);
    fault_stb <= 1'b0;
    wt(6);
  end
  endtask

  task meas(input [1:0] r, input [11:0] v);
  begin
    @(posedge clk);
    meas_stb <= 1'b1;
    meas_rail <= r;
    meas_mv <= v;
    @(posedge clk);
    meas_stb <= 1'b0;
  end
  endtask

  // rail voltage of fault k is the 12'h100 + rail measured before it
  function [31:0] ent(input integer k);
    ent = {14'h0, k[1:0], k[3:0], 10'h040, k[1:0]};
  endfunction

  ////////////////////////////////////////
  initial
  begin
    err_count = 0;
    check_count = 0;
    {rst_n, hsel, hwrite, fault_stb, meas_stb, nv_restore, slow} = 7'h00;
    ce = 1'b1;
    {htrans, fault_rail, meas_rail, fault_type, meas_mv} = 22'h0;
    hsize = 3'h2;
    haddr = 8'h00;
    hwdata = 32'h0;
    vcc_mv = 12'hB54;
    nv_rtc_ms = 32'h0;
    nv_rtc_day = 32'h0;
    nv_rst_cnt = 16'h0007;
    wt(5);
    rst_n <= 1'b1;
    wt(8);
    chk(nvm.cnt[4], 1);
    rd(`FLOG_A_RST_CNT, 32'h8);
    rd(`FLOG_A_RTC_DAY, 32'h0);
    rd(`FLOG_A_CTRL, 32'h0);
    rd(8'h40, 32'h0);
    chk(brownout, 0);
    bus(1'b1, `FLOG_A_RTC_DAY, 32'h5);
    rd(`FLOG_A_RTC_DAY, 32'h5);
    bus(1'b1, `FLOG_A_RTC_MS, 32'h0526_5BFF);
    wt(20010);
    rd(`FLOG_A_RTC_DAY, 32'h6);
    bus(1'b1, `FLOG_A_CTRL, 32'h400);
    wt(10);
    chk(nvm.cnt[3], 1);
    bus(1'b1, `FLOG_A_CTRL, 32'h200);
    rd(`FLOG_A_RST_CNT, 32'h0);
    // peaks against a slow flash; only the interval maximum is stored
    slow <= 1'b1;
    n = nvm.cnt[1];
    meas(2'h1, 12'h200);
    meas(2'h1, 12'h300);
    meas(2'h1, 12'h250);
    wt(40);
    chk(nvm.cnt[1], n + 1);
    bus(1'b1, `FLOG_A_SEL, 32'h1);
    rd(`FLOG_A_PEAK, 32'h300);
    meas(2'h2, 12'h150);
    wt(40);
    bus(1'b1, `FLOG_A_SEL, 32'h2);
    rd(`FLOG_A_PEAK, 32'h150);
    // a write while the clock enable is low must be ignored
    ce <= 1'b0;
    bus(1'b1, `FLOG_A_SEL, 32'h3);
    ce <= 1'b1;
    rd(`FLOG_A_SEL, 32'h2);
    for (i = 0; i < 4; i = i + 1)
      meas(i[1:0], 12'h100 + i[11:0]);
    // policies: no fifo, full, half, no fifo again after a clear
    for (p = 0; p < 4; p = p + 1)
    begin
      bus(1'b1, `FLOG_A_CTRL, p % 3);
      bus(1'b1, `FLOG_A_CTRL, (p % 3) | 32'h100);
      bus(1'b0, `FLOG_A_STAT, 32'h0);
      chk(rv[4:0], 0);
      for (i = 0; i < 20; i = i + 1)
        flt(i);
      bus(1'b0, `FLOG_A_STAT, 32'h0);
      chk(rv[4:0], 18);
      for (s = 0; s < 18; s = s + 1)
      begin
        f = s;
        if (p == 1 && s < 2)
          f = s + 18;
        if (p == 2 && (s == 9 || s == 10))
          f = s + 9;
        bus(1'b1, `FLOG_A_SEL, s);
        rd(`FLOG_A_ENT_INFO, ent(f));
        rd(`FLOG_A_ENT_DAY, 32'h6);
      end
    end
    // brownout mode: nothing reaches flash until the supply drops
    slow <= 1'b0;
    bus(1'b1, `FLOG_A_CTRL, 32'h104);
    n = nvm.total;
    flt(3);
    meas(2'h3, 12'h400);
    wt(60);
    chk(nvm.total, n);
    bus(1'b1, `FLOG_A_SEL, 32'h3);
    rd(`FLOG_A_PEAK, 32'h400);
    vcc_mv <= 12'hB53;
    wt(10);
    chk(brownout, 1);
    chk(nvm.cnt[5], 1);
    bus(1'b0, `FLOG_A_STAT, 32'h0);
    chk(rv[8], 1);
    // second reset with a preserved clock image
    rst_n <= 1'b0;
    nv_restore <= 1'b1;
    nv_rtc_day <= 32'h9;
    nv_rtc_ms <= 32'h1234;
    nv_rst_cnt <= 16'h0010;
    vcc_mv <= 12'hB54;
    wt(5);
    rst_n <= 1'b1;
    wt(8);
    rd(`FLOG_A_RTC_DAY, 32'h9);
    rd(`FLOG_A_RST_CNT, 32'h11);
    chk(brownout, 0);
    rd(`FLOG_A_ENT_INFO, 32'h0);
    flt(5);
    rd(`FLOG_A_ENT_INFO, 32'h0001_5000);
    rd(`FLOG_A_ENT_MS, 32'h1234);
    rd(`FLOG_A_ENT_DAY, 32'h9);
    complete_run;
  end

  // hang guard well above the expected run length
  initial
  begin
    repeat (90000) @(posedge clk);
    err_count = err_count + 1;
    complete_run;
  end
endmodule
